// ===== design/lec_ctrl.sv
// Lookup engine control register with AHB-Lite slave, frame filter and flush triggers
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module lec_ctrl
    import lec_pkg::*;
#(
    parameter int NPORTS = 4,
    parameter int PW = (NPORTS > 1) ? $clog2(NPORTS) : 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic learn_en,
    output logic sa_filt_en,
    output logic mc_src_fwd,
    output logic age_en,
    output logic fast_age_en,
    input wire logic rx_valid,
    input wire logic [PW-1:0] rx_port,
    input wire logic [47:0] rx_sa,
    output logic chk_valid,
    output logic chk_drop,
    output logic chk_drop_self,
    output logic chk_drop_mcast,
    input wire logic [NPORTS-1:0] link_up,
    output logic ld_flush_valid,
    output logic [NPORTS-1:0] ld_flush_ports,
    output logic tbl_flush_req,
    output logic [1:0] tbl_flush_scope,
    input wire logic tbl_flush_done,
    output logic mstp_flush_req,
    output logic [1:0] mstp_flush_scope,
    input wire logic mstp_flush_done
);

    typedef struct packed {
        logic [7:0] ctrl;
        logic learn_en;
        logic [1:0] scope;
        logic [NPORTS-1:0] port_filt;
        logic [47:0] mac;
        logic dph_wr;
        logic rd_pend;
        logic [29:0] dph_addr;
        logic hready_o;
        logic hresp_o;
        logic [31:0] rdata;
        logic chk_valid;
        logic chk_drop;
        logic chk_self;
        logic chk_mc;
        logic [NPORTS-1:0] ls1;
        logic [NPORTS-1:0] ls2;
        logic [NPORTS-1:0] ls3;
        logic ld_valid;
        logic [NPORTS-1:0] ld_ports;
    } lec_st_t;

    lec_st_t r;
    lec_st_t n;

    logic acc;
    logic wr_ctrl;
    logic tbl_start;
    logic mstp_start;
    logic tbl_busy;
    logic mstp_busy;
    logic port_en;
    logic self_hit;
    logic mc_hit;
    logic [NPORTS-1:0] fall;
    logic [7:0] ctrl_view;

    // Word address match against a register index
    function automatic logic lec_hit(input logic [29:0] wa, input logic [11:0] idx);
        return wa == {18'h0, idx};
    endfunction

    assign acc = hsel && htrans[1] && hready;
    assign wr_ctrl = r.dph_wr && lec_hit(r.dph_addr, LEC_IDX_CTRL1);
    assign tbl_start = wr_ctrl && hwdata[LEC_B_FLUSH_TBL];
    assign mstp_start = wr_ctrl && hwdata[LEC_B_FLUSH_MSTP];

    // Trigger bits read back as one while their flush runs
    assign ctrl_view = {r.ctrl[LEC_B_LEARN_DIS], r.ctrl[LEC_B_SA_FILT], tbl_busy, mstp_busy,
                        r.ctrl[3:0]};

    // Out-of-range port numbers never enable the self-address filter
    assign port_en = (32'(rx_port) < NPORTS) && r.port_filt[rx_port];
    assign self_hit = rx_valid && r.ctrl[LEC_B_SA_FILT] && port_en && (rx_sa == r.mac);
    assign mc_hit = rx_valid && rx_sa[LEC_SA_MC_BIT] && !r.ctrl[LEC_B_MC_FWD];

    // Falling edge on the synchronised link level
    assign fall = r.ls3 & ~r.ls2;

    always_comb begin
        n = r;
        // Address phase: writes complete with no wait, reads take one wait state
        n.dph_wr = acc && hwrite && (hsize == LEC_HSIZE_WORD);
        n.rd_pend = acc && !hwrite;
        if (acc) begin
            n.dph_addr = haddr[31:2];
        end
        if (acc && !hwrite) begin
            n.hready_o = 1'b0;
        end
        if (r.rd_pend) begin
            n.hready_o = 1'b1;
            n.rdata = '0;
            if (lec_hit(r.dph_addr, LEC_IDX_CTRL1)) begin
                n.rdata[7:0] = ctrl_view;
            end else if (lec_hit(r.dph_addr, LEC_IDX_SCOPE)) begin
                n.rdata[1:0] = r.scope;
            end else if (lec_hit(r.dph_addr, LEC_IDX_PFILT)) begin
                n.rdata[NPORTS-1:0] = r.port_filt;
            end else if (lec_hit(r.dph_addr, LEC_IDX_MACLO)) begin
                n.rdata = r.mac[31:0];
            end else if (lec_hit(r.dph_addr, LEC_IDX_MACHI)) begin
                n.rdata[15:0] = r.mac[47:32];
            end
        end
        n.hresp_o = LEC_HRESP_OKAY;

        // Data phase of a write
        if (r.dph_wr) begin
            if (lec_hit(r.dph_addr, LEC_IDX_CTRL1)) begin
                // Trigger bits are not stored; they start the flush engines
                n.ctrl = hwdata[7:0] & LEC_CTRL1_CFG_MASK;
            end else if (lec_hit(r.dph_addr, LEC_IDX_SCOPE)) begin
                n.scope = hwdata[1:0];
            end else if (lec_hit(r.dph_addr, LEC_IDX_PFILT)) begin
                n.port_filt = hwdata[NPORTS-1:0];
            end else if (lec_hit(r.dph_addr, LEC_IDX_MACLO)) begin
                n.mac[31:0] = hwdata;
            end else if (lec_hit(r.dph_addr, LEC_IDX_MACHI)) begin
                n.mac[47:32] = hwdata[15:0];
            end
        end
        n.learn_en = ~n.ctrl[LEC_B_LEARN_DIS];

        // Frame source check, answered one cycle after the request
        n.chk_valid = rx_valid;
        n.chk_self = self_hit;
        n.chk_mc = mc_hit;
        n.chk_drop = self_hit || mc_hit;

        // Link level synchroniser and link-down flush request
        n.ls1 = link_up;
        n.ls2 = r.ls1;
        n.ls3 = r.ls2;
        n.ld_valid = r.ctrl[LEC_B_LD_FLUSH] && (|fall);
        n.ld_ports = r.ctrl[LEC_B_LD_FLUSH] ? fall : '0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.ctrl <= LEC_CTRL1_RST;
            r.learn_en <= 1'b1;
            r.scope <= LEC_SCOPE_RST;
            r.hready_o <= 1'b1;
        end else begin
            r <= n;
        end
    end

    lec_flush u_tbl_flush (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(tbl_start),
        .scope(r.scope),
        .done(tbl_flush_done),
        .busy(tbl_busy),
        .req_scope(tbl_flush_scope)
    );

    lec_flush u_mstp_flush (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(mstp_start),
        .scope(r.scope),
        .done(mstp_flush_done),
        .busy(mstp_busy),
        .req_scope(mstp_flush_scope)
    );

    assign hreadyout = r.hready_o;
    assign hresp = r.hresp_o;
    assign hrdata = r.rdata;
    assign learn_en = r.learn_en;
    assign sa_filt_en = r.ctrl[LEC_B_SA_FILT];
    assign mc_src_fwd = r.ctrl[LEC_B_MC_FWD];
    assign age_en = r.ctrl[LEC_B_AGE_EN];
    assign fast_age_en = r.ctrl[LEC_B_FAST_AGE];
    assign chk_valid = r.chk_valid;
    assign chk_drop = r.chk_drop;
    assign chk_drop_self = r.chk_self;
    assign chk_drop_mcast = r.chk_mc;
    assign ld_flush_valid = r.ld_valid;
    assign ld_flush_ports = r.ld_ports;
    assign tbl_flush_req = tbl_busy;
    assign mstp_flush_req = mstp_busy;

    default clocking lec_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_rd_taken;
        acc && !hwrite;
    endsequence

    sequence s_rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    sequence s_tbl_trig;
        wr_ctrl && hwdata[LEC_B_FLUSH_TBL] && !tbl_busy && r.scope != LEC_SCOPE_NONE;
    endsequence

    sequence s_mstp_trig;
        wr_ctrl && hwdata[LEC_B_FLUSH_MSTP] && !mstp_busy && r.scope != LEC_SCOPE_NONE;
    endsequence

    a_read_wait: assert property (s_rd_taken |=> s_rd_answer)
        else $error("read answer not after exactly one wait state");

    a_learn_ctl: assert property (wr_ctrl |=> learn_en == !$past(hwdata[LEC_B_LEARN_DIS]))
        else $error("learning enable does not follow control write");

    a_self_drop: assert property (rx_valid && r.ctrl[LEC_B_SA_FILT] && port_en && rx_sa == r.mac
        |=> chk_valid && chk_drop && chk_drop_self)
        else $error("self-addressed frame not dropped");

    a_self_global: assert property (!r.ctrl[LEC_B_SA_FILT] || !port_en |=> !chk_drop_self)
        else $error("self filter acted without both enables");

    a_tbl_start: assert property (s_tbl_trig |=> tbl_flush_req && tbl_flush_scope == $past(r.scope))
        else $error("table flush did not start on write of one");

    a_tbl_readback: assert property (tbl_flush_req && !tbl_flush_done
        |=> tbl_flush_req ##0 (!r.rd_pend || !lec_hit(r.dph_addr, LEC_IDX_CTRL1)
        || ctrl_view[LEC_B_FLUSH_TBL]))
        else $error("table flush bit cleared before done");

    a_scope_kept: assert property (tbl_flush_req && !tbl_flush_done |=> $stable(tbl_flush_scope))
        else $error("flush scope changed during flush");

    a_mstp_start: assert property (s_mstp_trig |=> mstp_flush_req [*2] or
        (mstp_flush_req ##1 $past(mstp_flush_done)))
        else $error("instance flush did not start on write of one");

    a_scope_none: assert property (wr_ctrl && r.scope == LEC_SCOPE_NONE && !tbl_busy
        |=> !tbl_flush_req)
        else $error("flush started with empty scope");

    a_mc_drop: assert property (rx_valid && rx_sa[LEC_SA_MC_BIT] && !mc_src_fwd
        |=> chk_drop && chk_drop_mcast)
        else $error("multicast source frame not dropped");

    a_mc_fwd: assert property (mc_src_fwd && !self_hit |=> !chk_drop)
        else $error("frame dropped while multicast sources forwarded");

    a_age_ctl: assert property (wr_ctrl |=> age_en == $past(hwdata[LEC_B_AGE_EN])
        && fast_age_en == $past(hwdata[LEC_B_FAST_AGE]))
        else $error("aging controls do not follow control write");

    a_ld_flush: assert property ($fell(r.ls2[0]) && r.ctrl[LEC_B_LD_FLUSH]
        |=> ld_flush_valid && ld_flush_ports[0])
        else $error("link loss did not raise flush");

    a_ld_off: assert property (!r.ctrl[LEC_B_LD_FLUSH] |=> !ld_flush_valid)
        else $error("link-down flush raised while disabled");

    a_ld_quiet: assert property (!ld_flush_valid |-> ld_flush_ports == '0)
        else $error("link-down port mask set without flush pulse");

    a_trig_clear: assert property (wr_ctrl
        |=> !r.ctrl[LEC_B_FLUSH_TBL] && !r.ctrl[LEC_B_FLUSH_MSTP])
        else $error("flush trigger bit stored in control register");

    a_tbl_done: assert property (tbl_flush_req && tbl_flush_done
        |=> !tbl_flush_req && tbl_flush_scope == LEC_SCOPE_NONE)
        else $error("table flush not idle after done");

    a_mstp_kept: assert property (mstp_flush_req && !mstp_flush_done
        |=> mstp_flush_req && $stable(mstp_flush_scope))
        else $error("instance flush dropped or scope changed before done");

    a_filt_ctl: assert property (wr_ctrl
        |=> sa_filt_en == $past(hwdata[LEC_B_SA_FILT]) && mc_src_fwd == $past(hwdata[LEC_B_MC_FWD]))
        else $error("filter controls do not follow control write");

    a_write_nowait: assert property (acc && hwrite |=> hreadyout)
        else $error("write data phase inserted a wait state");

endmodule

// ===== design/lec_flush.sv
// One self-clearing flush trigger and its request to the table engine
`timescale 1ns/1ns
module lec_flush
    import lec_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic [1:0] scope,
    input wire logic done,
    output logic busy,
    output logic [1:0] req_scope
);

    typedef struct packed {
        lec_fl_state_t state;
        logic [1:0] scope;
        logic busy;
    } lec_fl_st_t;

    lec_fl_st_t r;
    lec_fl_st_t n;

    always_comb begin
        n = r;
        unique case (r.state)
            LEC_FL_IDLE: begin
                // Scope none has no eligible entries, so nothing starts
                if (start && scope != LEC_SCOPE_NONE) begin
                    n.state = LEC_FL_REQ;
                    n.scope = scope;
                end
            end
            LEC_FL_REQ: begin
                // Only the engine's done ends it; software cannot cancel
                if (done) begin
                    n.state = LEC_FL_IDLE;
                    n.scope = LEC_SCOPE_NONE;
                end
            end
        endcase
        n.busy = (n.state == LEC_FL_REQ);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign busy = r.busy;
    assign req_scope = r.scope;

    a_flush_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        r.busy && !done |=> r.busy)
        else $error("flush request dropped before done");
    a_flush_scope: assert property (@(posedge hclk) disable iff (!hresetn)
        !r.busy && start && scope != LEC_SCOPE_NONE |=> r.busy && r.scope == $past(scope))
        else $error("flush did not start with captured scope");

endmodule

// ===== design/lec_pkg.sv
// Constants and types shared by the lookup engine control block
// Notes on behaviour
// - Bit 7 set stops unicast source learning.
// - Drop frames whose source equals switch MAC.
// - Self filtering needs global bit and port bit.
// - Bit 5 write-one starts whole-table flush, self-clears.
// - Flushes remove entries within the flush scope.
// - Bit 4 write-one starts spanning-tree instance flush.
// - Bit 3 clear drops multicast source frames.
// - Bit 2 enables aging, resets to one.
// - Bit 1 selects fast aging, resets zero.
// - Bit 0 flushes ports whose link drops.
// - Scope codes: none, dynamic, static, both.
package lec_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] LEC_IDX_CTRL1 = 12'h311;
    localparam logic [11:0] LEC_IDX_SCOPE = 12'h320;
    localparam logic [11:0] LEC_IDX_PFILT = 12'h321;
    localparam logic [11:0] LEC_IDX_MACLO = 12'h322;
    localparam logic [11:0] LEC_IDX_MACHI = 12'h323;

    // Control register fields and reset value
    localparam int LEC_B_LEARN_DIS = 7;
    localparam int LEC_B_SA_FILT = 6;
    localparam int LEC_B_FLUSH_TBL = 5;
    localparam int LEC_B_FLUSH_MSTP = 4;
    localparam int LEC_B_MC_FWD = 3;
    localparam int LEC_B_AGE_EN = 2;
    localparam int LEC_B_FAST_AGE = 1;
    localparam int LEC_B_LD_FLUSH = 0;
    localparam logic [7:0] LEC_CTRL1_RST = 8'h0C;
    localparam logic [7:0] LEC_CTRL1_CFG_MASK = 8'hCF;

    // Flush scope codes
    localparam logic [1:0] LEC_SCOPE_NONE = 2'h0;
    localparam logic [1:0] LEC_SCOPE_DYN = 2'h1;
    localparam logic [1:0] LEC_SCOPE_STAT = 2'h2;
    localparam logic [1:0] LEC_SCOPE_BOTH = 2'h3;
    localparam logic [1:0] LEC_SCOPE_RST = 2'h0;

    // Group bit of the first address octet
    localparam int LEC_SA_MC_BIT = 40;

    // Bus encodings
    localparam logic [2:0] LEC_HSIZE_WORD = 3'h2;
    localparam logic LEC_HRESP_OKAY = 1'b0;

    typedef enum logic [0:0] {
        LEC_FL_IDLE = 1'b0,
        LEC_FL_REQ = 1'b1
    } lec_fl_state_t;

endpackage

// ===== sim/lookup_engine_control_one_bench.sv
// Self-checking bench for the lookup engine control register block
`timescale 1ns/1ns
module lookup_engine_control_one_bench;
    import lec_pkg::*;
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, learn_en, sa_filt_en, mc_src_fwd, age_en, fast_age_en;
    logic [31:0] hrdata;
    logic rx_valid = 1'b0;
    logic [1:0] rx_port = 2'h0;
    logic [47:0] rx_sa = 48'h0;
    logic chk_valid, chk_drop, chk_drop_self, chk_drop_mcast, ld_flush_valid;
    logic [3:0] link_up = 4'hF;
    logic [3:0] ld_flush_ports;
    logic tbl_flush_req, mstp_flush_req;
    logic [1:0] tbl_flush_scope, mstp_flush_scope;
    logic tbl_flush_done = 1'b0;
    logic mstp_flush_done = 1'b0;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] rd;
    localparam logic [31:0] A_CTRL = {18'h0, LEC_IDX_CTRL1, 2'h0};
    localparam logic [31:0] A_SCOPE = {18'h0, LEC_IDX_SCOPE, 2'h0};
    localparam logic [31:0] A_PFILT = {18'h0, LEC_IDX_PFILT, 2'h0};
    localparam logic [31:0] A_MACLO = {18'h0, LEC_IDX_MACLO, 2'h0};
    localparam logic [31:0] A_MACHI = {18'h0, LEC_IDX_MACHI, 2'h0};
    localparam logic [47:0] MAC = 48'h0A1B2C3D4E5F;

    lec_ctrl #(.NPORTS(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .learn_en(learn_en), .sa_filt_en(sa_filt_en), .mc_src_fwd(mc_src_fwd),
        .age_en(age_en), .fast_age_en(fast_age_en), .rx_valid(rx_valid), .rx_port(rx_port), .rx_sa(rx_sa),
        .chk_valid(chk_valid), .chk_drop(chk_drop), .chk_drop_self(chk_drop_self),
        .chk_drop_mcast(chk_drop_mcast), .link_up(link_up), .ld_flush_valid(ld_flush_valid),
        .ld_flush_ports(ld_flush_ports), .tbl_flush_req(tbl_flush_req), .tbl_flush_scope(tbl_flush_scope),
        .tbl_flush_done(tbl_flush_done), .mstp_flush_req(mstp_flush_req),
        .mstp_flush_scope(mstp_flush_scope), .mstp_flush_done(mstp_flush_done));

    always #50 hclk = ~hclk;

    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // Single word transfer; waits on hready in both phases
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= LEC_HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
        `CHK("hresp", LEC_HRESP_OKAY, hresp)
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
        repeat (2) @(posedge hclk);
    endtask

    task automatic t_reset();
        ahb(1'b0, A_CTRL, 32'h0, rd);
        `CHK("ctrl reset", 32'h0000000C, rd)
        `CHK("learn_en", 1'b1, learn_en)
        `CHK("sa_filt_en", 1'b0, sa_filt_en)
        `CHK("mc_src_fwd", 1'b1, mc_src_fwd)
        `CHK("age_en", 1'b1, age_en)
        `CHK("fast_age_en", 1'b0, fast_age_en)
        ahb(1'b0, 32'h00000C40, 32'h0, rd);
        `CHK("unmapped read", 32'h0, rd)
        $display("test reset done");
    endtask

    task automatic t_cfg();
        wr(A_CTRL, 32'h000000C3);
        ahb(1'b0, A_CTRL, 32'h0, rd);
        `CHK("ctrl C3", 32'h000000C3, rd)
        `CHK("learn off", 1'b0, learn_en)
        `CHK("fast on", 1'b1, fast_age_en)
        `CHK("age off", 1'b0, age_en)
        `CHK("mc drop", 1'b0, mc_src_fwd)
        wr(A_CTRL, 32'h0000000C);
        `CHK("learn on", 1'b1, learn_en)
        `CHK("age on", 1'b1, age_en)
        $display("test config done");
    endtask

    task automatic frame(input logic [1:0] p, input logic [47:0] sa, input logic es, input logic em);
        @(posedge hclk);
        rx_valid <= 1'b1;
        rx_port <= p;
        rx_sa <= sa;
        @(posedge hclk);
        rx_valid <= 1'b0;
        #1;
        `CHK("chk_valid", 1'b1, chk_valid)
        `CHK("drop_self", es, chk_drop_self)
        `CHK("drop_mcast", em, chk_drop_mcast)
        `CHK("drop", es | em, chk_drop)
    endtask

    task automatic t_filter();
        wr(A_MACLO, MAC[31:0]);
        wr(A_MACHI, {16'h0, MAC[47:32]});
        wr(A_PFILT, 32'h00000002);
        ahb(1'b0, A_MACHI, 32'h0, rd);
        `CHK("mac hi", MAC[47:32], rd[15:0])
        ahb(1'b0, A_MACLO, 32'h0, rd);
        `CHK("mac lo", MAC[31:0], rd)
        ahb(1'b0, A_PFILT, 32'h0, rd);
        `CHK("port filt", 32'h00000002, rd)
        frame(2'h1, MAC, 1'b0, 1'b0);
        wr(A_CTRL, 32'h0000004C);
        `CHK("sa_filt_en on", 1'b1, sa_filt_en)
        frame(2'h1, MAC, 1'b1, 1'b0);
        frame(2'h2, MAC, 1'b0, 1'b0);
        frame(2'h1, MAC ^ 48'h1, 1'b0, 1'b0);
        frame(2'h0, 48'h010000000001, 1'b0, 1'b0);
        wr(A_CTRL, 32'h00000044);
        frame(2'h0, 48'h010000000001, 1'b0, 1'b1);
        frame(2'h0, 48'h000000000001, 1'b0, 1'b0);
        wr(A_CTRL, 32'h0000000C);
        $display("test filter done");
    endtask

    task automatic flush(input logic m, input logic [1:0] sc);
        logic [31:0] trig;
        trig = m ? 32'h1C : 32'h2C;
        wr(A_SCOPE, {30'h0, sc});
        ahb(1'b0, A_SCOPE, 32'h0, rd);
        `CHK("scope reg", sc, rd[1:0])
        wr(A_CTRL, trig);
        `CHK("req", sc != 2'h0, m ? mstp_flush_req : tbl_flush_req)
        `CHK("scope", sc, m ? mstp_flush_scope : tbl_flush_scope)
        if (sc != 2'h0) begin
            ahb(1'b0, A_CTRL, 32'h0, rd);
            `CHK("busy bit", trig[7:0], rd[7:0])
            wr(A_CTRL, 32'h0000000C);
            `CHK("req kept", 1'b1, m ? mstp_flush_req : tbl_flush_req)
            @(posedge hclk);
            if (m) mstp_flush_done <= 1'b1;
            else tbl_flush_done <= 1'b1;
            @(posedge hclk);
            mstp_flush_done <= 1'b0;
            tbl_flush_done <= 1'b0;
            repeat (2) @(posedge hclk);
            `CHK("req off", 1'b0, m ? mstp_flush_req : tbl_flush_req)
            `CHK("scope idle", LEC_SCOPE_NONE, m ? mstp_flush_scope : tbl_flush_scope)
        end
        ahb(1'b0, A_CTRL, 32'h0, rd);
        `CHK("self clear", 32'h0000000C, rd)
    endtask

    task automatic t_flush();
        for (int i = 0; i < 8; i++) begin
            flush(i[2], i[1:0]);
        end
        $display("test flush done");
    endtask

    task automatic t_link(input logic en);
        int n;
        logic [3:0] mk;
        n = 0;
        mk = 4'h0;
        wr(A_CTRL, {31'h6, en});
        @(posedge hclk);
        link_up <= 4'hA;
        repeat (8) begin
            @(posedge hclk);
            if (ld_flush_valid === 1'b1) begin
                n++;
                mk = ld_flush_ports;
            end
        end
        `CHK("ld pulses", en ? 1 : 0, n)
        `CHK("ld mask", en ? 4'h5 : 4'h0, mk)
        link_up <= 4'hF;
        repeat (4) @(posedge hclk);
        $display("test link down done");
    endtask

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_cfg();
        t_filter();
        t_flush();
        t_link(1'b1);
        t_link(1'b0);
        report_and_stop();
    end
endmodule
